// [rtl/acc_pkg.sv]
/*
  Constants for the converter control block: register offsets, field positions,
  reset values and conversion timing.
  Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package acc_pkg;

  // ************************************************************
  // Register map (printed offsets are not word aligned: indexes)
  // ************************************************************
  localparam logic [7:0]  RESULT_IDX      = 8'h00_D0;
  localparam logic [7:0]  CONTROL_IDX     = 8'h00_D1;
  localparam logic [7:0]  MODE_IDX        = 8'h00_D2;
  localparam logic [11:0] RESULT_ADDR     = {2'b00, RESULT_IDX, 2'b00};
  localparam logic [11:0] CONTROL_ADDR    = {2'b00, CONTROL_IDX, 2'b00};
  localparam logic [11:0] MODE_ADDR       = {2'b00, MODE_IDX, 2'b00};

  // ************************************************************
  // Control register fields and reset values
  // ************************************************************
  localparam int          IRQ_EN_BIT      = 7;
  localparam int          DONE_BIT        = 6;
  localparam int          START_BIT       = 5;
  localparam int          POWER_BIT       = 4;
  localparam int          OSC_OFF_BIT     = 2;
  localparam int          WAIT_BIT        = 0;
  localparam int          STOP_BIT        = 1;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00_40;
  localparam logic [7:0]  RESULT_RESET    = 8'h00_00;
  localparam logic [7:0]  FULL_SCALE      = 8'h00_FF;
  localparam logic [7:0]  ZERO_SCALE      = 8'h00_00;

  // ************************************************************
  // Timing: 70 us conversion, 8 successive-approximation steps
  // ************************************************************
  localparam int          CLK_MHZ         = 100;
  localparam int          CONV_TIME_US    = 70;
  localparam int          RESULT_BITS     = 8;
  localparam int          CONV_CYCLES     = CONV_TIME_US * CLK_MHZ;
  localparam int          STEP_CYCLES     = CONV_CYCLES / RESULT_BITS;

  // AXI response codes
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage

// [rtl/acc_step_timer.sv]
/*
  Step pacing for the approximation sequencer: one enable pulse per bit trial.
  Assumes the caller restarts it on every fresh conversion.
*/
module acc_step_timer
  import acc_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic run,
  input  wire logic restart,
  // Pacing
  output logic      step_en
);

  logic [15:0] cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart || !run)
      cnt_reg <= 16'h0000;
    else if (cnt_reg == 16'(STEP_LEN - 1))
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end

  assign step_en = run && !restart && (cnt_reg == 16'(STEP_LEN - 1));

endmodule

// [rtl/acc_sar_core.sv]
/*
  Successive-approximation register: trials one bit per step from the top,
  keeping it when the comparator reports the input at or above the trial code.
  Assumes the comparator input is already synchronised to aclk.
*/
module acc_sar_core
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Sequencing
  input  wire logic       load,
  input  wire logic       step_en,
  input  wire logic       comp_ge,
  // Trial and result
  output logic [7:0]      trial_code,
  output logic [2:0]      bit_idx,
  output logic            last_step
);

  logic [7:0] sar_reg;
  logic [2:0] idx_reg;

  assign trial_code = sar_reg;
  assign bit_idx    = idx_reg;
  assign last_step  = step_en && (idx_reg == 3'd0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sar_reg <= 8'h00_80;
      idx_reg <= 3'd7;
    end
    else if (load)
    begin
      sar_reg <= 8'h00_80;
      idx_reg <= 3'd7;
    end
    else if (step_en)
    begin
      // Keep or drop the trial bit, then raise the next one down
      sar_reg[idx_reg] <= comp_ge;
      if (idx_reg != 3'd0)
      begin
        sar_reg[idx_reg - 3'd1] <= 1'b1;
        idx_reg                 <= idx_reg - 3'd1;
      end
    end
  end

endmodule

// [rtl/acc_adc_ctrl.sv]
/*
  Converter control block: AXI4-Lite register slave, start/done flag logic,
  power and low-power mode gating, and the completion interrupt.
  Assumes an analog comparator outside that compares the input with the
  trial code on dac_code and returns comp_ge_async on a pin; the core
  drives the wait and stop mode levels.
*/
// The address map and the AXI4-Lite register port were left to the implementer.
// Summary of operation
// - Eight-bit successive approximation result held in a software-readable register.
// - Input at or above high reference yields FFh, with no overflow flag.
// - Input at or below low reference yields 00h.
// - Conversion takes about 70 us, timing scaled to the core clock.
// - Writing one to start begins a conversion and clears done at once.
// - Done is set on completion and marks the result as valid.
// - Interrupt request is done AND interrupt enable.
// - One conversion per start write; no automatic restart.
// - Start during a running conversion abandons it and starts afresh.
// - Start bit is write-only and always reads zero.
// - Writing zero to done has no effect; only a start clears it.
// - Clearing the power bit switches the converter off.
// - Converter keeps running in wait mode; its interrupt wakes from wait.
// - Power bit zero means off, one means on.
// - Control register resets to done set, everything else clear.
module acc_adc_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog front end
  input  wire logic        comp_ge_async,
  output logic [7:0]       dac_code,
  output logic             analog_power_on,
  // Core power modes and wake
  input  wire logic        core_wait_mode,
  input  wire logic        core_stop_mode,
  output logic             done_irq,
  output logic             wake_request,
  output logic             osc_off
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } acc_state_t;

  acc_state_t  state_reg;
  acc_state_t  state_next;
  logic [7:0]  result_holding_reg;
  logic        done_reg;
  logic        done_irq_enable_reg;
  logic        converter_power_on_reg;
  logic        osc_off_reg;
  logic        comp_meta_reg;
  logic        comp_sync_reg;

  // Bus side
  logic [11:0] awaddr_reg;
  logic        aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  logic        wr_fire;
  logic        ctrl_wr;
  logic        start_pulse;
  logic        active;
  logic        step_en;
  logic        last_step;
  logic [7:0]  trial_code;
  logic [2:0]  bit_idx;
  logic [7:0]  control_view;

  // ************************************************************
  // Comparator synchroniser
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end
    else
    begin
      comp_meta_reg <= comp_ge_async;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // Address and data are captured independently, in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
  assign ctrl_wr       = wr_fire && (awaddr_reg == CONTROL_ADDR) && wstrb_reg[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 12'h0_000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        // Result is read-only; unmapped writes are refused
        bresp_reg   <= (awaddr_reg == CONTROL_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  // Start only counts when powered and not in stop mode
  assign start_pulse = ctrl_wr && wdata_reg[START_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_irq_enable_reg    <= CONTROL_RESET[IRQ_EN_BIT];
      converter_power_on_reg <= CONTROL_RESET[POWER_BIT];
      osc_off_reg            <= CONTROL_RESET[OSC_OFF_BIT];
    end
    else if (ctrl_wr)
    begin
      done_irq_enable_reg    <= wdata_reg[IRQ_EN_BIT];
      converter_power_on_reg <= wdata_reg[POWER_BIT];
      osc_off_reg            <= wdata_reg[OSC_OFF_BIT];
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  // Power off or stop mode freezes the converter and drops any conversion
  assign active = converter_power_on_reg && !core_stop_mode;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_pulse && active)
          state_next = ST_CONV;
      ST_CONV:
        if (!active)
          state_next = ST_IDLE;
        else if (start_pulse)
          state_next = ST_CONV;
        else if (last_step)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  acc_step_timer u_step_timer
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (state_reg == ST_CONV),
    .restart (start_pulse),
    .step_en (step_en)
  );

  acc_sar_core u_sar_core
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (start_pulse),
    .step_en    (step_en && active),
    .comp_ge    (comp_sync_reg),
    .trial_code (trial_code),
    .bit_idx    (bit_idx),
    .last_step  (last_step)
  );

  // ************************************************************
  // Result and done flag
  // ************************************************************
  // Final code is the trial with the last bit decided; saturates to FFh or 00h
  // naturally, so no overflow indication exists
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_holding_reg <= RESULT_RESET;
    else if (state_reg == ST_CONV && last_step && active && !start_pulse)
      result_holding_reg <= {trial_code[7:1], comp_sync_reg};
  end

  // A new start clears done; a write of zero to done is ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_reg <= CONTROL_RESET[DONE_BIT];
    else if (start_pulse && active)
      done_reg <= 1'b0;
    else if (state_reg == ST_CONV && last_step && active)
      done_reg <= 1'b1;
  end

  assign done_irq        = done_reg && done_irq_enable_reg;
  assign wake_request    = done_irq && core_wait_mode && !core_stop_mode;
  assign dac_code        = trial_code;
  assign analog_power_on = converter_power_on_reg;
  assign osc_off         = osc_off_reg;

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  // Start reads zero; reserved bits read zero
  assign control_view = {done_irq_enable_reg, done_reg, 1'b0, converter_power_on_reg,
                         1'b0, osc_off_reg, 2'b00};

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      case (s_axi_araddr)
        RESULT_ADDR:  rdata_reg <= {24'h00_0000, result_holding_reg};
        CONTROL_ADDR: rdata_reg <= {24'h00_0000, control_view};
        MODE_ADDR:    rdata_reg <= {30'h0000_0000, core_stop_mode, core_wait_mode};
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_start_taken;
    start_pulse && active;
  endsequence

  a_start_clears_done: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start_taken |=> !done_reg)
    else $error("done not cleared by start");

  a_irq_follows_done: assert property (@(posedge aclk) disable iff (!aresetn)
    done_irq == (done_reg && done_irq_enable_reg))
    else $error("irq not done and enable");

  a_no_self_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_IDLE && !start_pulse) |=> state_reg == ST_IDLE)
    else $error("conversion began without start");

  a_restart_reloads: assert property (@(posedge aclk) disable iff (!aresetn)
    ((state_reg == ST_CONV) and s_start_taken) |=> (state_reg == ST_CONV && bit_idx == 3'd7))
    else $error("restart did not reload");

  a_start_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == CONTROL_ADDR) |=> !rdata_reg[START_BIT])
    else $error("start bit read as one");

  a_done_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_reg && !start_pulse) |=> done_reg)
    else $error("done fell without start");

  a_power_off_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    !converter_power_on_reg |=> state_reg == ST_IDLE)
    else $error("converter ran while off");

  a_stop_no_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    core_stop_mode |-> !wake_request)
    else $error("wake during stop");

  a_done_sets_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_CONV && last_step && active && !start_pulse) |=> done_reg)
    else $error("done not set at completion");

endmodule

// [verif/acc_adc_ctrl_test.sv]
/*
  Self-checking bench for the converter control block: register access over
  AXI4-Lite, conversion timing, start/done flag rules, power and low-power modes.
  Assumes the design carries its own assertions and that the comparator pin is
  modelled here from an analog input value held by the bench.
*/
module acc_adc_ctrl_test
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals
  // ************************************************************
  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        comp_ge_async, analog_power_on, core_wait_mode, core_stop_mode;
  logic [7:0]  dac_code;
  logic        done_irq, wake_request, osc_off;
  logic [8:0]  vin;
  int          n_fail, check_count, cyc;

  acc_adc_ctrl i_acc_adc_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .comp_ge_async(comp_ge_async),
    .dac_code(dac_code), .analog_power_on(analog_power_on), .core_wait_mode(core_wait_mode),
    .core_stop_mode(core_stop_mode), .done_irq(done_irq), .wake_request(wake_request),
    .osc_off(osc_off));

  always #5 aclk = ~aclk;

  // Comparator: input values above 255 stand for a level beyond the high reference
  always @(posedge aclk)
  begin
    comp_ge_async <= (vin >= {1'b0, dac_code});
  end

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ceiling covers six full conversions plus the aborted ones with margin
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      n_fail++;
      test_done();
    end
  end

  function automatic logic [7:0] exp_code(input logic [8:0] v);
    return (v > 9'd255) ? FULL_SCALE : v[7:0];
  endfunction

  // ************************************************************
  // Bus master tasks: handshakes seen between edges, released on the edge
  // ************************************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_h, w_h, b_h, fin;
    fin = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!fin)
    begin
      @(negedge aclk);
      aw_h = s_axi_awvalid && s_axi_awready;
      w_h = s_axi_wvalid && s_axi_wready;
      b_h = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_h) s_axi_awvalid <= 1'b0;
      if (w_h) s_axi_wvalid <= 1'b0;
      if (b_h) s_axi_bready <= 1'b0;
      fin = b_h;
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_h, fin;
    fin = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!fin)
    begin
      @(negedge aclk);
      ar_h = s_axi_arvalid && s_axi_arready;
      fin = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_h) s_axi_arvalid <= 1'b0;
      if (fin) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(what, d, {24'h0000_00, exp});
    chk("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // Counts cycles until the interrupt line rises, bounded
  task automatic wait_done(output int n);
    n = 0;
    while (done_irq !== 1'b1 && n < 9000)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  logic [8:0]  vins [4];
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  held;
  int          n;

  initial
  begin
    aclk = 0; aresetn = 0; vin = 9'h000; comp_ge_async = 0;
    s_axi_awaddr = 0; s_axi_awvalid = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hF; s_axi_wvalid = 0;
    s_axi_bready = 0; s_axi_araddr = 0; s_axi_arvalid = 0; s_axi_rready = 0;
    core_wait_mode = 0; core_stop_mode = 0; n_fail = 0; check_count = 0; cyc = 0;
    n = $urandom(71);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("control reset", CONTROL_ADDR, CONTROL_RESET);
    rd_chk("result reset", RESULT_ADDR, RESULT_RESET);
    chk("irq after reset", {31'h0, done_irq}, 32'h0);
    rd(12'h0F0, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    // Writing done as zero leaves it set; power bit one turns the converter on
    wr(CONTROL_ADDR, 32'h0000_0090, r);
    chk("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd_chk("done kept", CONTROL_ADDR, 8'h00_D0);
    chk("power on", {31'h0, analog_power_on}, 32'h1);
    vins[0] = 9'h000;
    vins[1] = 9'h12C;
    vins[2] = 9'($urandom_range(1, 254));
    vins[3] = 9'($urandom_range(1, 254));
    foreach (vins[i])
    begin
      vin <= vins[i];
      wr(CONTROL_ADDR, 32'h0000_00B0, r);
      rd_chk("done cleared, start reads 0", CONTROL_ADDR, 8'h00_90);
      chk("irq low in flight", {31'h0, done_irq}, 32'h0);
      wait_done(n);
      chk("conv time", {31'h0, (n >= 6950 && n <= 7050)}, 32'h1);
      rd_chk("result", RESULT_ADDR, exp_code(vins[i]));
    end
    // No further conversion after completion
    held = dac_code;
    repeat (1000) @(posedge aclk);
    chk("no self restart", {24'h0, dac_code}, {24'h0, held});
    rd_chk("done stays", CONTROL_ADDR, 8'h00_D0);
    // Restart mid conversion: full time counted from the second start
    wr(CONTROL_ADDR, 32'h0000_00B0, r);
    repeat (3000) @(posedge aclk);
    wr(CONTROL_ADDR, 32'h0000_00B0, r);
    wait_done(n);
    chk("restart time", {31'h0, (n >= 6950 && n <= 7050)}, 32'h1);
    wr(CONTROL_ADDR, 32'h0000_0010, r);
    chk("irq off by enable", {31'h0, done_irq}, 32'h0);
    rd_chk("done with irq off", CONTROL_ADDR, 8'h00_50);
    // Wait mode keeps converting and wakes; stop mode does not wake
    core_wait_mode <= 1'b1;
    wr(CONTROL_ADDR, 32'h0000_00B0, r);
    wait_done(n);
    chk("wait conv time", {31'h0, (n >= 6950 && n <= 7050)}, 32'h1);
    @(posedge aclk);
    chk("wake from wait", {31'h0, wake_request}, 32'h1);
    rd_chk("mode read", MODE_ADDR, 8'h00_01);
    core_stop_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("no wake in stop", {31'h0, wake_request}, 32'h0);
    core_stop_mode <= 1'b0;
    core_wait_mode <= 1'b0;
    // Stop mode mid conversion aborts it
    wr(CONTROL_ADDR, 32'h0000_00B0, r);
    repeat (3000) @(posedge aclk);
    core_stop_mode <= 1'b1;
    repeat (10) @(posedge aclk);
    core_stop_mode <= 1'b0;
    repeat (7100) @(posedge aclk);
    rd_chk("stop aborts", CONTROL_ADDR, 8'h00_90);
    // Power off mid conversion aborts it
    wr(CONTROL_ADDR, 32'h0000_00B0, r);
    repeat (3000) @(posedge aclk);
    wr(CONTROL_ADDR, 32'h0000_0080, r);
    chk("power off", {31'h0, analog_power_on}, 32'h0);
    repeat (7100) @(posedge aclk);
    rd_chk("power off aborts", CONTROL_ADDR, 8'h00_80);
    // Oscillator bit is plain storage; low strobe and result writes change nothing
    wr(CONTROL_ADDR, 32'h0000_0084, r);
    chk("osc off", {31'h0, osc_off}, 32'h1);
    rd_chk("osc readback", CONTROL_ADDR, 8'h00_84);
    s_axi_wstrb <= 4'hE;
    wr(CONTROL_ADDR, 32'h0000_0000, r);
    s_axi_wstrb <= 4'hF;
    rd_chk("low strobe ignored", CONTROL_ADDR, 8'h00_84);
    wr(RESULT_ADDR, 32'h0000_0000, r);
    chk("result write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    rd_chk("result kept", RESULT_ADDR, exp_code(vins[3]));
    test_done();
  end
endmodule
